/* File: design/mmc_cycle_timer.sv */
// Access cycle sequencer: setup delay, strobe and wait states
`timescale 1ns/1ps
module mmc_cycle_timer import mmc_pkg::*; #(
   parameter int WS_W = 3
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Request
   input wire logic start_i,
   input wire logic [WS_W-1:0] wait_states_i,
   input wire logic delay_start_i,
   // Status
   output logic strobe_o,
   output logic done_o,
   output logic busy_o
);
   initial begin
      if (WS_W < 1 || WS_W > 8) $error("WS_W out of range");
   end

   mmc_cyc_state_type state_q; // Sequencer state
   logic [WS_W-1:0] count_q; // Remaining wait states

   // Strobe rises after optional setup cycle, falls after waits
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         state_q <= CY_IDLE;
         count_q <= '0;
         strobe_o <= 1'b0;
         done_o <= 1'b0;
         busy_o <= 1'b0;
      end else begin
         done_o <= 1'b0;
         case (state_q)
            CY_IDLE: begin
               if (start_i) begin
                  count_q <= wait_states_i;
                  busy_o <= 1'b1;
                  // Slow memory gets one clock of extra setup
                  strobe_o <= ~delay_start_i;
                  state_q <= delay_start_i ? CY_SETUP : CY_WAIT;
               end
            end
            CY_SETUP: begin
               strobe_o <= 1'b1;
               state_q <= CY_WAIT;
            end
            CY_WAIT: begin
               if (count_q == '0) begin
                  strobe_o <= 1'b0;
                  done_o <= 1'b1;
                  state_q <= CY_DONE;
               end else begin
                  count_q <= count_q - 1'b1;
               end
            end
            CY_DONE: begin
               busy_o <= 1'b0;
               state_q <= CY_IDLE;
            end
            default: begin
               state_q <= CY_IDLE;
               strobe_o <= 1'b0;
               busy_o <= 1'b0;
            end
         endcase
      end
   end
endmodule

/* File: design/mmc_pkg.sv */
// Types shared by the memory mapper controller
package mmc_pkg;
   // Memory type held in a mapper entry
   typedef enum logic [1:0] {
      MMC_T_RAM = 2'h0,
      MMC_T_BOOT_ROM_SPACE = 2'h1,
      MMC_T_SECOND_ROM_SPACE = 2'h2,
      MMC_T_EXP = 2'h3
   } mmc_mem_type_type;
   // Access cycle sequencer states
   typedef enum logic [3:0] {
      CY_IDLE = 4'h1,
      CY_SETUP = 4'h2,
      CY_WAIT = 4'h4,
      CY_DONE = 4'h8
   } mmc_cyc_state_type;
   // Refresh sequencer states
   typedef enum logic [3:0] {
      RF_IDLE = 4'h1,
      RF_CAS = 4'h2,
      RF_RAS = 4'h4,
      RF_END = 4'h8
   } mmc_rf_state_type;
endpackage

/* File: design/mmc_regs.svh */
// Register offsets, field positions, reset values and timing counts
`ifndef MMC_REGS_SVH
`define MMC_REGS_SVH
// Direct I/O ports
`define MMC_IO_MAP_SEL 8'h6C
`define MMC_IO_MAP_LO 8'h6E
`define MMC_IO_MAP_HI 8'h6F
`define MMC_IO_INDEX 8'h22
`define MMC_IO_DATA 8'h23
// Indexed registers
`define MMC_IX_MEMCTL1 8'h04
`define MMC_IX_MEMCTL2 8'h05
`define MMC_IX_APIN1 8'h14
`define MMC_IX_APIN2 8'h15
`define MMC_IX_APIN3 8'h16
`define MMC_IX_ROMWS 8'h7C
`define MMC_IX_RAMWS 8'h7D
`define MMC_IX_RFSH 8'h7F
`define MMC_IX_SHD_ADDR 8'hE8
`define MMC_IX_SHD_CTL 8'hE9
// Memory control one and two bits
`define MMC_MC1_MAPEN 0
`define MMC_MC1_LATCH 1
`define MMC_MC1_VGA 2
`define MMC_MC1_DRAM 3
`define MMC_MC1_BANKS 4
`define MMC_MC1_SLOW 5
`define MMC_MC2_SECOND_ROM_SPACE_BYTE 0
// Mapper entry fields
`define MMC_ENT_EN 15
`define MMC_ENT_TYPE_HI 13
`define MMC_ENT_TYPE_LO 12
`define MMC_ENT_PAGE_HI 9
// Shadow control bits
`define MMC_SHD_WRRAM 7
`define MMC_SHD_RDRAM 6
// CPU segments (address bits 19:16) and entry base of the C to E windows
`define MMC_SEG_A 4'hA
`define MMC_SEG_B 4'hB
`define MMC_SEG_C 4'hC
`define MMC_SEG_E 4'hE
`define MMC_SEG_BIOS 4'hF
`define MMC_WIN_BASE 4'h4
// Reset values
`define MMC_RST_BYTE 8'h00
`define MMC_RST_RFSH 8'hFF
// Timing
`define MMC_CLK_NS 50
`define MMC_RFSH_TICK_NS 15260
`define MMC_RFSH_TICK_CYC (`MMC_RFSH_TICK_NS / `MMC_CLK_NS)
`endif

/* File: design/mmc_top.sv */
// Memory mapper controller: mapper, pins, wait states, refresh, shadow
`timescale 1ns/1ps
`include "mmc_regs.svh"
module mmc_top import mmc_pkg::*; #(
   parameter int TICK_CYC = `MMC_RFSH_TICK_CYC
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // I/O register port
   input wire logic io_wr_i,
   input wire logic io_rd_i,
   input wire logic [7:0] io_addr_i,
   input wire logic [7:0] io_wdata_i,
   output logic [7:0] io_rdata_o,
   // CPU memory cycle
   input wire logic mem_start_i,
   input wire logic mem_wr_i,
   input wire logic [19:0] cpu_addr_i,
   output logic mem_ready_o,
   // Strap pin
   input wire logic rom_byte_strap_i,
   // Physical memory side
   output logic [23:0] phys_addr_o,
   output logic ram_sel_o,
   output logic boot_rom_select_o,
   output logic second_rom_select_o,
   output logic exp_sel_o,
   output logic mem_strobe_o,
   output logic mem_we_o,
   output logic rom_byte_mode_o,
   // Refresh strobes
   output logic rfsh_cas_o,
   output logic rfsh_cas_odd_o,
   output logic rfsh_ras_o
);
   initial begin
      if (TICK_CYC < 1 || TICK_CYC > 65535) $error("TICK_CYC out of range");
   end

   // Window decode: {valid, entry index} from CPU address bits 19:12
   function automatic logic [4:0] win_index(input logic [7:0] hi, input logic vga);
      logic [5:0] q;
      q = hi[7:2];
      win_index = 5'h00;
      if (hi[7:4] >= `MMC_SEG_C && hi[7:4] <= `MMC_SEG_E) begin
         win_index = {1'b1, 4'(q[3:0] + `MMC_WIN_BASE)};
      end else if (hi[7:4] == (vga ? `MMC_SEG_B : `MMC_SEG_A)) begin
         win_index = {3'b100, q[1:0]};
      end
   endfunction

   // Registers
   logic [7:0] index_q; // Indexed register pointer
   logic [7:0] mc1_q; // Memory control one
   logic [7:0] mc2_q; // Memory control two
   logic [7:0] apin1_q; // RAM and boot ROM pin enables
   logic [7:0] apin2_q; // Second ROM enables, latch 19:16
   logic [7:0] apin3_q; // Latch 15:12
   logic [7:0] romws_q; // ROM wait states
   logic [7:0] ramws_q; // RAM wait states
   logic [7:0] rfsh_q; // Refresh period
   logic [7:0] shd_addr_q; // Shadow start, bits 23:16
   logic [7:0] shd_ctl_q; // Shadow control
   logic [7:0] map_sel_q; // Mapper entry select
   logic [15:0] map_mem [16]; // Mapper entries
   logic [4:0] sel_win; // Decoded select port window
   logic [15:0] sel_ent; // Entry addressed by select port

   assign sel_win = win_index(map_sel_q, mc1_q[`MMC_MC1_VGA]);
   assign sel_ent = map_mem[sel_win[3:0]];

   // Direct ports and indexed register writes
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         index_q <= `MMC_RST_BYTE;
         map_sel_q <= `MMC_RST_BYTE;
         mc1_q <= `MMC_RST_BYTE;
         mc2_q <= `MMC_RST_BYTE;
         apin1_q <= `MMC_RST_BYTE;
         apin2_q <= `MMC_RST_BYTE;
         apin3_q <= `MMC_RST_BYTE;
         romws_q <= `MMC_RST_BYTE;
         ramws_q <= `MMC_RST_BYTE;
         rfsh_q <= `MMC_RST_RFSH;
         shd_addr_q <= `MMC_RST_BYTE;
         shd_ctl_q <= `MMC_RST_BYTE;
      end else if (io_wr_i) begin
         case (io_addr_i)
            `MMC_IO_INDEX: index_q <= io_wdata_i;
            `MMC_IO_MAP_SEL: map_sel_q <= io_wdata_i;
            `MMC_IO_DATA: begin
               case (index_q)
                  `MMC_IX_MEMCTL1: mc1_q <= io_wdata_i;
                  `MMC_IX_MEMCTL2: mc2_q <= io_wdata_i;
                  `MMC_IX_APIN1: apin1_q <= io_wdata_i;
                  `MMC_IX_APIN2: apin2_q <= io_wdata_i;
                  `MMC_IX_APIN3: apin3_q <= io_wdata_i;
                  `MMC_IX_ROMWS: romws_q <= io_wdata_i;
                  `MMC_IX_RAMWS: ramws_q <= io_wdata_i;
                  `MMC_IX_RFSH: rfsh_q <= io_wdata_i;
                  `MMC_IX_SHD_ADDR: shd_addr_q <= io_wdata_i;
                  `MMC_IX_SHD_CTL: shd_ctl_q <= io_wdata_i;
                  default: ;
               endcase
            end
            default: ;
         endcase
      end
   end

   // Mapper entry storage; data writes land on the selected window
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         for (int i = 0; i < 16; i++) begin
            map_mem[i] <= 16'h0000;
         end
      end else if (io_wr_i && sel_win[4]) begin
         // Select must already name the window
         if (io_addr_i == `MMC_IO_MAP_LO) begin
            map_mem[sel_win[3:0]][7:0] <= io_wdata_i;
         end else if (io_addr_i == `MMC_IO_MAP_HI) begin
            map_mem[sel_win[3:0]][15:8] <= io_wdata_i;
         end
      end
   end

   // Register read data, unknown addresses read zero
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         io_rdata_o <= `MMC_RST_BYTE;
      end else if (io_rd_i) begin
         case (io_addr_i)
            `MMC_IO_INDEX: io_rdata_o <= index_q;
            `MMC_IO_MAP_SEL: io_rdata_o <= map_sel_q;
            `MMC_IO_MAP_LO: io_rdata_o <= sel_win[4] ? sel_ent[7:0] : `MMC_RST_BYTE;
            `MMC_IO_MAP_HI: io_rdata_o <= sel_win[4] ? sel_ent[15:8] : `MMC_RST_BYTE;
            `MMC_IO_DATA: begin
               case (index_q)
                  `MMC_IX_MEMCTL1: io_rdata_o <= mc1_q;
                  `MMC_IX_MEMCTL2: io_rdata_o <= mc2_q;
                  `MMC_IX_APIN1: io_rdata_o <= apin1_q;
                  `MMC_IX_APIN2: io_rdata_o <= apin2_q;
                  `MMC_IX_APIN3: io_rdata_o <= apin3_q;
                  `MMC_IX_ROMWS: io_rdata_o <= romws_q;
                  `MMC_IX_RAMWS: io_rdata_o <= ramws_q;
                  `MMC_IX_RFSH: io_rdata_o <= rfsh_q;
                  `MMC_IX_SHD_ADDR: io_rdata_o <= shd_addr_q;
                  `MMC_IX_SHD_CTL: io_rdata_o <= shd_ctl_q;
                  default: io_rdata_o <= `MMC_RST_BYTE;
               endcase
            end
            default: io_rdata_o <= `MMC_RST_BYTE;
         endcase
      end
   end

   // Strap: two-stage sync, caught once after reset release
   logic strap_m_q; // First sync stage
   logic strap_s_q; // Second sync stage
   logic strap_arm_q; // First edge after release seen
   logic strap_wait_q; // Second stage now holds the pin
   logic strap_done_q; // Strap captured
   logic boot_rom_space_byte_q; // Boot ROM is byte wide
   // Capture waits two edges so the sync stages hold the pin, not reset zeros
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         strap_m_q <= 1'b0;
         strap_s_q <= 1'b0;
         strap_arm_q <= 1'b0;
         strap_wait_q <= 1'b0;
         strap_done_q <= 1'b0;
         boot_rom_space_byte_q <= 1'b0;
      end else begin
         strap_m_q <= rom_byte_strap_i;
         strap_s_q <= strap_m_q;
         strap_arm_q <= 1'b1;
         strap_wait_q <= strap_arm_q;
         strap_done_q <= strap_wait_q;
         if (strap_wait_q && !strap_done_q) begin
            boot_rom_space_byte_q <= strap_s_q;
         end
      end
   end

   // Address translation for the present CPU address
   logic [4:0] cpu_win; // Window of the CPU address
   logic [15:0] cpu_ent; // Its mapper entry
   logic [23:0] tr_addr; // Physical address
   logic [1:0] tr_type; // Target memory type
   logic tr_sel; // Some memory is selected
   logic tr_wblock; // Write is dropped
   assign cpu_win = win_index(cpu_addr_i[19:12], mc1_q[`MMC_MC1_VGA]);
   assign cpu_ent = map_mem[cpu_win[3:0]];

   always_comb begin
      tr_addr = {4'h0, cpu_addr_i};
      tr_type = MMC_T_RAM;
      tr_sel = 1'b1;
      tr_wblock = 1'b0;
      if (cpu_addr_i[19:16] == `MMC_SEG_BIOS) begin
         if (shd_ctl_q[`MMC_SHD_RDRAM]) begin
            // Shadow read: read RAM, writes refused unless MMC_SHD_WRRAM is also set
            tr_addr = {shd_addr_q, cpu_addr_i[15:0]};
            tr_wblock = mem_wr_i & ~shd_ctl_q[`MMC_SHD_WRRAM];
         end else if (shd_ctl_q[`MMC_SHD_WRRAM] && mem_wr_i) begin
            tr_addr = {shd_addr_q, cpu_addr_i[15:0]};
         end else begin
            // Boot ROM, upper bits forced low
            tr_addr = {8'h00, cpu_addr_i[15:0]};
            tr_type = MMC_T_BOOT_ROM_SPACE;
         end
      end else if (cpu_win[4]) begin
         if (mc1_q[`MMC_MC1_MAPEN] && cpu_ent[`MMC_ENT_EN]) begin
            tr_addr = {cpu_ent[`MMC_ENT_PAGE_HI:0], cpu_addr_i[13:0]};
            tr_type = cpu_ent[`MMC_ENT_TYPE_HI:`MMC_ENT_TYPE_LO];
         end else begin
            tr_sel = 1'b0;
         end
      end
      // Below the windows: plain system RAM, display area as RAM too
   end

   // Per-type wait states and pin enables
   logic [2:0] tr_ws; // Wait states for the cycle
   logic [3:0] tr_pin_en; // Upper pin enables for the type
   always_comb begin
      case (tr_type)
         MMC_T_RAM: begin
            tr_ws = ramws_q[2:0];
            tr_pin_en = apin1_q[3:0];
         end
         MMC_T_BOOT_ROM_SPACE: begin
            tr_ws = romws_q[2:0];
            tr_pin_en = apin1_q[7:4];
         end
         MMC_T_SECOND_ROM_SPACE: begin
            tr_ws = romws_q[6:4];
            tr_pin_en = apin2_q[3:0];
         end
         default: begin
            tr_ws = 3'h0;
            tr_pin_en = 4'hF;
         end
      endcase
   end

   // Pin values with latching of disabled or held pins
   logic io_cyc; // I/O cycle on the bus
   logic [23:0] pin_d; // Next pin values
   logic [11:0] hold_mid; // Latch config for 19:12
   assign io_cyc = io_wr_i | io_rd_i;
   assign hold_mid = {apin2_q[7:4], apin3_q[3:0], 4'h0};
   always_comb begin
      pin_d = tr_addr;
      for (int i = 0; i < 4; i++) begin
         if (!tr_pin_en[i]) begin
            // Disabled pin holds when latching, else low
            pin_d[20+i] = mc1_q[`MMC_MC1_LATCH] & phys_addr_o[20+i];
         end
      end
      for (int i = 12; i < 20; i++) begin
         if (mc1_q[`MMC_MC1_LATCH] && hold_mid[i-8] && tr_type == MMC_T_RAM
             && mc1_q[`MMC_MC1_DRAM]) begin
            pin_d[i] = phys_addr_o[i];
         end
      end
   end

   // Cycle control
   logic cyc_go; // Start of an access
   logic pend_q; // Request waiting behind refresh
   logic cyc_busy; // Sequencer busy
   logic cyc_done; // Sequencer finished
   logic cyc_strobe; // Sequencer strobe
   logic rf_busy; // Refresh owns the memory
   mmc_rf_state_type rf_q; // Refresh state
   assign rf_busy = (rf_q != RF_IDLE);
   assign cyc_go = (mem_start_i | pend_q) & ~rf_busy & ~cyc_busy;

   // Hold a CPU request while a refresh runs
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         pend_q <= 1'b0;
      end else if (cyc_go) begin
         pend_q <= 1'b0;
      end else if (mem_start_i) begin
         pend_q <= 1'b1;
      end
   end

   mmc_cycle_timer #(
      .WS_W(3)
   ) u_timer (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .start_i(cyc_go),
      .wait_states_i(tr_ws),
      .delay_start_i(mc1_q[`MMC_MC1_SLOW] & (tr_type == MMC_T_RAM)),
      .strobe_o(cyc_strobe),
      .done_o(cyc_done),
      .busy_o(cyc_busy)
   );

   // Address pins and selects, held through the access
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         phys_addr_o <= 24'h000000;
         ram_sel_o <= 1'b0;
         boot_rom_select_o <= 1'b0;
         second_rom_select_o <= 1'b0;
         exp_sel_o <= 1'b0;
         mem_we_o <= 1'b0;
         rom_byte_mode_o <= 1'b0;
      end else if (cyc_go) begin
         phys_addr_o <= pin_d;
         ram_sel_o <= tr_sel & (tr_type == MMC_T_RAM);
         boot_rom_select_o <= tr_sel & (tr_type == MMC_T_BOOT_ROM_SPACE);
         second_rom_select_o <= tr_sel & (tr_type == MMC_T_SECOND_ROM_SPACE);
         exp_sel_o <= tr_sel & (tr_type == MMC_T_EXP);
         mem_we_o <= mem_wr_i & ~tr_wblock;
         rom_byte_mode_o <= (tr_type == MMC_T_BOOT_ROM_SPACE) ? boot_rom_space_byte_q :
            (tr_type == MMC_T_SECOND_ROM_SPACE) & mc2_q[`MMC_MC2_SECOND_ROM_SPACE_BYTE];
      end else if (io_cyc && !cyc_busy) begin
         // I/O cycle: configured 19:16 keep the last value
         phys_addr_o[15:0] <= cpu_addr_i[15:0];
         for (int i = 16; i < 20; i++) begin
            phys_addr_o[i] <= (mc1_q[`MMC_MC1_LATCH] && hold_mid[i-8]) ? phys_addr_o[i] : cpu_addr_i[i];
         end
      end else if (cyc_done) begin
         ram_sel_o <= 1'b0;
         boot_rom_select_o <= 1'b0;
         second_rom_select_o <= 1'b0;
         exp_sel_o <= 1'b0;
         mem_we_o <= 1'b0;
      end
   end

   // Strobe and ready follow the sequencer
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         mem_strobe_o <= 1'b0;
         mem_ready_o <= 1'b0;
      end else begin
         mem_strobe_o <= cyc_strobe & (ram_sel_o | boot_rom_select_o | second_rom_select_o | exp_sel_o);
         mem_ready_o <= cyc_done;
      end
   end

   // Refresh tick prescaler and period counter
   logic [15:0] pre_q; // Tick prescaler
   logic [7:0] rf_cnt_q; // Ticks since last request
   logic rf_req_q; // Refresh owed
   logic rf_take; // Refresh starts now
   assign rf_take = rf_req_q & (rf_q == RF_IDLE) & ~cyc_busy & ~cyc_go;
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         pre_q <= 16'h0000;
         rf_cnt_q <= 8'h00;
         rf_req_q <= 1'b0;
      end else begin
         if (pre_q == 16'(TICK_CYC - 1)) begin
            pre_q <= 16'h0000;
            // Period is the register value in ticks, zero acts as one
            if (rf_cnt_q + 8'h01 >= rfsh_q) begin
               rf_cnt_q <= 8'h00;
               rf_req_q <= 1'b1;
            end else begin
               rf_cnt_q <= rf_cnt_q + 8'h01;
               if (rf_take) rf_req_q <= 1'b0;
            end
         end else begin
            pre_q <= pre_q + 16'h0001;
            if (rf_take) rf_req_q <= 1'b0;
         end
      end
   end

   // Column-before-row refresh, odd bank column one cycle late when the banks bit is set, else with the first
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         rf_q <= RF_IDLE;
         rfsh_cas_o <= 1'b0;
         rfsh_cas_odd_o <= 1'b0;
         rfsh_ras_o <= 1'b0;
      end else begin
         case (rf_q)
            RF_IDLE: begin
               if (rf_take) begin
                  rfsh_cas_o <= 1'b1;
                  rfsh_cas_odd_o <= ~mc1_q[`MMC_MC1_BANKS];
                  rf_q <= RF_CAS;
               end
            end
            RF_CAS: begin
               rfsh_cas_odd_o <= 1'b1;
               rfsh_ras_o <= 1'b1;
               rf_q <= RF_RAS;
            end
            RF_RAS: begin
               rf_q <= RF_END;
            end
            RF_END: begin
               rfsh_cas_o <= 1'b0;
               rfsh_cas_odd_o <= 1'b0;
               rfsh_ras_o <= 1'b0;
               rf_q <= RF_IDLE;
            end
            default: begin
               rf_q <= RF_IDLE;
               rfsh_cas_o <= 1'b0;
               rfsh_cas_odd_o <= 1'b0;
               rfsh_ras_o <= 1'b0;
            end
         endcase
      end
   end
endmodule

/* File: test/memory_mapper_controller_test.sv */
// Testbench for the memory mapper controller
`timescale 1ns/1ps
module memory_mapper_controller_test;
   // Stimulus and observed signals
   logic clk_i = 0, rst_i = 1, io_wr_i = 0, io_rd_i = 0, mem_start_i = 0, mem_wr_i = 0;
   logic rom_byte_strap_i = 1;
   logic [7:0] io_addr_i = 8'h00, io_wdata_i = 8'h00, io_rdata_o;
   logic [19:0] cpu_addr_i = 20'h00000;
   logic [23:0] phys_addr_o, seen_a;
   logic mem_ready_o, ram_sel_o, boot_rom_select_o, second_rom_select_o, exp_sel_o, mem_strobe_o;
   logic mem_we_o, rom_byte_mode_o, rfsh_cas_o, rfsh_cas_odd_o, rfsh_ras_o;
   logic [5:0] seen_s; // Selects, write enable, byte mode
   int n_fail = 0, samples_checked = 0, ram_wr_cnt, seen_n;
   always #25 clk_i = ~clk_i;
   mmc_top #(.TICK_CYC(4)) uut (.*);
   mmc_mem_model m0 (.clk_i(clk_i), .ram_sel_i(ram_sel_o), .mem_strobe_i(mem_strobe_o),
      .mem_we_i(mem_we_o), .ram_wr_cnt(ram_wr_cnt));
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("BAD %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic step();
      @(posedge clk_i);
      #2;
   endtask
   task automatic iow(input logic [7:0] a, input logic [7:0] d);
      step();
      io_wr_i = 1;
      io_addr_i = a;
      io_wdata_i = d;
      step();
      io_wr_i = 0;
   endtask
   task automatic ixw(input logic [7:0] i, input logic [7:0] d);
      iow(8'h22, i);
      iow(8'h23, d);
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      step();
      io_rd_i = 1;
      io_addr_i = a;
      step();
      io_rd_i = 0;
      step();
      chk("io_rdata_o", io_rdata_o, e);
   endtask
   // One memory cycle, held until ready; selects caught one edge after start
   task automatic mem(input logic [19:0] a, input logic w);
      step();
      mem_start_i = 1;
      cpu_addr_i = a;
      mem_wr_i = w;
      step();
      mem_start_i = 0;
      step();
      seen_a = phys_addr_o;
      seen_s = {ram_sel_o, boot_rom_select_o, second_rom_select_o, exp_sel_o, mem_we_o, rom_byte_mode_o};
      seen_n = 1;
      while (mem_ready_o !== 1'b1 && seen_n < 40) begin
         step();
         seen_n++;
      end
      if (seen_n >= 40) begin
         n_fail++;
         wrap_up();
      end
   endtask
   task automatic t_regs();
      iow(8'h22, 8'h7F);
      rd(8'h23, 8'hFF);
      ixw(8'h7D, 8'h05);
      rd(8'h23, 8'h05);
      iow(8'h22, 8'h5A);
      rd(8'h23, 8'h00);
   endtask
   task automatic t_wait();
      int n0;
      ixw(8'h7D, 8'h00);
      mem(20'h01234, 1'b0);
      n0 = seen_n;
      chk("low ram", {seen_a, seen_s[5:2]}, {24'h001234, 4'b1000});
      ixw(8'h7D, 8'h07);
      mem(20'h01234, 1'b0);
      chk("ram wait", seen_n, n0 + 7);
      ixw(8'h04, 8'h20);
      mem(20'h01234, 1'b0);
      chk("slow start", seen_n, n0 + 8);
      ixw(8'h04, 8'h00);
      ixw(8'h7C, 8'h03);
      mem(20'hF0000, 1'b0);
      chk("bios wait", seen_n, n0 + 3);
      chk("bios sel", {seen_s[5:2], seen_s[0]}, 5'b01001);
   endtask
   task automatic t_map();
      ixw(8'h14, 8'hFF);
      ixw(8'h15, 8'h0F);
      ixw(8'h04, 8'h01);
      ixw(8'h05, 8'h01);
      iow(8'h6C, 8'hC4);
      iow(8'h6E, 8'h55);
      for (int t = 3; t >= 0; t--) begin
         iow(8'h6F, {2'b10, t[1:0], 4'h1});
         mem(20'hC5ABC, 1'b0);
         chk("type sel", {seen_s[5:2], seen_a[19:0]}, {4'b1000 >> t, 20'h55ABC});
         chk("byte mode", seen_s[0], (t == 1 || t == 2));
      end
      chk("mapped", seen_a, 24'h555ABC);
      rd(8'h6F, 8'h81);
      ixw(8'h14, 8'hF0);
      ixw(8'h15, 8'hFF);
      ixw(8'h04, 8'h03);
      mem(20'hC5ABC, 1'b0);
      chk("latched", seen_a, 24'h555ABC);
      rd(8'h6F, 8'h81);
      chk("io hold", phys_addr_o[19:0], 20'h55ABC);
      ixw(8'h04, 8'h01);
      mem(20'hC5ABC, 1'b0);
      chk("pin off", seen_a, 24'h055ABC);
      iow(8'h6F, 8'h01);
      mem(20'hC5ABC, 1'b0);
      chk("entry off", seen_s[5:2], 4'b0000);
      iow(8'h6F, 8'h81);
      ixw(8'h04, 8'h00);
      mem(20'hC5ABC, 1'b0);
      chk("map off", seen_s[5:2], 4'b0000);
      ixw(8'h14, 8'h0F);
      ixw(8'h04, 8'h05);
      iow(8'h6C, 8'hB0);
      iow(8'h6E, 8'h00);
      iow(8'h6F, 8'h81);
      mem(20'hB0123, 1'b0);
      chk("b window", seen_a, 24'h400123);
   endtask
   task automatic t_shadow();
      int c;
      ixw(8'hE8, 8'h12);
      ixw(8'hE9, 8'h80);
      mem(20'hF0010, 1'b0);
      chk("copy read", seen_s[5:2], 4'b0100);
      c = ram_wr_cnt;
      mem(20'hF0010, 1'b1);
      chk("copy write", {seen_a, seen_s[5:1]}, {24'h120010, 5'b10001});
      chk("ram write", 8'(ram_wr_cnt - c), 8'h01);
      ixw(8'hE9, 8'h40);
      mem(20'hF0010, 1'b0);
      chk("shadow read", {seen_a, seen_s[5:2]}, {24'h120010, 4'b1000});
      c = ram_wr_cnt;
      mem(20'hF0010, 1'b1);
      chk("blocked", {seen_s[1], 8'(ram_wr_cnt - c)}, 9'h000);
   endtask
   // Wait for the start of a fresh refresh
   task automatic wrise();
      int k;
      k = 0;
      while (rfsh_cas_o === 1'b1 && k < 60) begin
         step();
         k++;
      end
      while (rfsh_cas_o !== 1'b1 && k < 60) begin
         step();
         k++;
      end
      if (k >= 60) begin
         n_fail++;
         wrap_up();
      end
   endtask
   task automatic t_rfsh();
      ixw(8'h04, 8'h10);
      ixw(8'h7F, 8'h02);
      for (int b = 1; b >= 0; b--) begin
         wrise();
         chk("rfsh first", {rfsh_cas_odd_o, rfsh_ras_o}, {!b[0], 1'b0});
         step();
         chk("rfsh second", {rfsh_cas_o, rfsh_cas_odd_o, rfsh_ras_o}, 3'b111);
         ixw(8'h04, 8'h00);
      end
   endtask
   // Main sequence
   initial begin
      repeat (12) @(posedge clk_i);
      #2 rst_i = 0;
      t_regs();
      t_wait();
      t_map();
      t_shadow();
      t_rfsh();
      wrap_up();
   end
endmodule

/* File: test/mmc_chk.sv */
// Port checks for the memory mapper controller
`timescale 1ns/1ps
module mmc_chk (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // CPU side
   input wire logic mem_start_i,
   input wire logic [19:0] cpu_addr_i,
   input wire logic mem_ready_o,
   // Memory side
   input wire logic [23:0] phys_addr_o,
   input wire logic ram_sel_o,
   input wire logic boot_rom_select_o,
   input wire logic second_rom_select_o,
   input wire logic exp_sel_o,
   input wire logic mem_strobe_o,
   // Refresh strobes
   input wire logic rfsh_cas_o,
   input wire logic rfsh_cas_odd_o,
   input wire logic rfsh_ras_o
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   // Column strobe leads, row strobe follows next cycle
   sequence s_cbr;
      rfsh_cas_o && !rfsh_ras_o ##1 rfsh_ras_o;
   endsequence
   property p_cbr;
      $rose(rfsh_cas_o) |-> s_cbr;
   endproperty
   a_cbr: assert property (p_cbr) else $error("row strobe not after column strobe");
   property p_ras_len;
      $rose(rfsh_ras_o) |-> rfsh_ras_o [*2] ##1 !rfsh_ras_o;
   endproperty
   a_ras_len: assert property (p_ras_len) else $error("refresh row strobe length wrong");
   property p_odd;
      $rose(rfsh_cas_o) |-> ##[0:1] rfsh_cas_odd_o;
   endproperty
   a_odd: assert property (p_odd) else $error("odd bank strobe late");
   property p_odd_cause;
      rfsh_cas_odd_o |-> rfsh_cas_o;
   endproperty
   a_odd_cause: assert property (p_odd_cause) else $error("odd bank strobe alone");
   property p_excl;
      rfsh_ras_o |-> !mem_strobe_o;
   endproperty
   a_excl: assert property (p_excl) else $error("access strobe during refresh");
   property p_one_sel;
      $onehot0({ram_sel_o, boot_rom_select_o, second_rom_select_o, exp_sel_o});
   endproperty
   a_one_sel: assert property (p_one_sel) else $error("two memory selects at once");
   property p_ready_pulse;
      mem_ready_o |=> !mem_ready_o;
   endproperty
   a_ready_pulse: assert property (p_ready_pulse) else $error("ready longer than a cycle");
   property p_ready_bound;
      mem_start_i |-> ##[2:24] mem_ready_o;
   endproperty
   a_ready_bound: assert property (p_ready_bound) else $error("access never finished");
   property p_offset;
      (ram_sel_o || boot_rom_select_o || second_rom_select_o || exp_sel_o)
         |-> phys_addr_o[13:0] == cpu_addr_i[13:0];
   endproperty
   a_offset: assert property (p_offset) else $error("page offset altered");
endmodule
bind mmc_top mmc_chk chk_i (.*);

/* File: test/mmc_mem_model.sv */
// Behavioural RAM side: counts word writes taken
`timescale 1ns/1ps
module mmc_mem_model (
   // Clock
   input wire logic clk_i,
   // Controls from the controller
   input wire logic ram_sel_i,
   input wire logic mem_strobe_i,
   input wire logic mem_we_i,
   // Accepted writes
   output int ram_wr_cnt
);
   logic stb_q = 1'b0; // Strobe one cycle ago
   initial ram_wr_cnt = 0;
   // One word write counted per strobe start with RAM selected and write enabled
   always @(posedge clk_i) begin
      stb_q <= mem_strobe_i;
      if (mem_strobe_i && !stb_q && ram_sel_i && mem_we_i) begin
         ram_wr_cnt <= ram_wr_cnt + 1;
      end
   end
endmodule
